// >>> arind_pkg.sv
`default_nettype none
package arind_pkg;
	localparam logic [15:0] CMD_NEW_REL  = 16'h0116;
	localparam logic [15:0] CMD_CFG_REP  = 16'h0117;
	localparam logic [15:0] MSG_INFO     = 16'h4002;
	localparam logic [15:0] FRAME_ONE    = 16'h0001;
	localparam logic [15:0] ZERO_WORD    = 16'h0000;
	localparam logic [15:0] SUB_PER_SLOT = 16'h0001;
	localparam logic [15:0] REL_TYPE_SINGLE    = 16'h0001;
	localparam logic [15:0] REL_TYPE_REDUN_CAP = 16'h0003;
	localparam logic [15:0] REL_TYPE_CTRL_RED  = 16'h0004;
	localparam logic [15:0] REL_TYPE_DEV_RED   = 16'h0005;
	localparam logic [15:0] REL_TYPE_SUPERVISOR = 16'h0006;
	localparam logic [2:0] KIND_SINGLE = 3'h0;
	localparam logic [2:0] KIND_REDUN  = 3'h1;
	localparam logic [2:0] KIND_CTRL   = 3'h2;
	localparam logic [2:0] KIND_DEV    = 3'h3;
	localparam logic [2:0] KIND_SUPER  = 3'h4;
	localparam int PROP_PAD_W = 21;
	localparam logic [31:0] PROP_UNUSED_MASK = 32'hffff_f880;
	localparam logic [3:0] HW_ID = 4'h0;
	localparam logic [3:0] HW_INFO = 4'h1;
	localparam logic [3:0] HW_CMD = 4'h2;
	localparam logic [3:0] HW_SIZE = 4'h3;
	localparam logic [3:0] HW_FCNT = 4'h4;
	localparam logic [3:0] HW_FNUM = 4'h5;
	localparam logic [3:0] HW_EXT1 = 4'h8;
	localparam logic [3:0] HW_EXT2 = 4'h9;
	localparam logic [3:0] HW_EXT3 = 4'ha;
	localparam logic [3:0] HW_EXT4 = 4'hb;
	localparam logic [3:0] HW_EXT5 = 4'hc;
	localparam logic [3:0] HW_LAST = 4'hf;
	localparam logic [3:0] BK_SLOT = 4'h0;
	localparam logic [3:0] BK_NSUB = 4'h1;
	localparam logic [3:0] BK_MIDH = 4'h2;
	localparam logic [3:0] BK_MIDL = 4'h3;
	localparam logic [3:0] BK_SSLOT = 4'h4;
	localparam logic [3:0] BK_SIDH = 4'h5;
	localparam logic [3:0] BK_SIDL = 4'h6;
	localparam logic [3:0] BK_INL = 4'h7;
	localparam logic [3:0] BK_LAST = 4'h8;
	localparam int BLK_WORDS = 9;
	localparam int FRAG_WORDS = 8;
	localparam int FRAG_SHIFT = 3;
	localparam logic [2:0] MAX_MOD = 3'h4;
	localparam logic [1:0] TW_SLOT = 2'h0;
	localparam logic [1:0] TW_MODID = 2'h1;
	localparam logic [1:0] TW_SUBID = 2'h2;
	localparam logic [1:0] TW_LEN = 2'h3;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_MASK = 12'h008;
	localparam logic [11:0] OFS_NMOD = 12'h00c;
	localparam logic [11:0] OFS_STATE = 12'h010;
	localparam logic [11:0] OFS_TABLE = 12'h040;
	localparam int CTRL_REL_INFO = 0;
	localparam int ST_REL = 0;
	localparam int ST_CFG = 1;
	localparam int ST_LOST = 2;
	localparam int IRQ_W = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ARIND_IDLE = 3'b001,
		ARIND_HDR  = 3'b010,
		ARIND_DATA = 3'b100
	} arind_state_t;
endpackage : arind_pkg
`default_nettype wire

// >>> arind_framer.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Emit new-relationship message per relationship established while idle; one arriving while busy is dropped and flagged lost.
// - Both messages only when relationship info enabled.
// - New-relationship header fixed; extended words type,props,handle.
// - Type word encodes relationship kind.
// - Properties bits: state, takeover, parameter server.
// - Properties bits: rate, access, companion; rest zero.
// - Config report uses its command, may fragment.
// - Report extended words: fragment, total, handle; size.
// - Last fragment number equals total fragment count.
// - Payload starts with module count, then blocks.
// - Module block: slot, submodule count, module id.
// - Submodule block: subslot, id, input, output lengths.
// - Submodule count is always one.
module arind_framer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        rel_est,
	input  wire logic [2:0]  rel_kind,
	input  wire logic [2:0]  rel_state,
	input  wire logic        rel_takeover,
	input  wire logic        rel_param_cm,
	input  wire logic [1:0]  rel_rate,
	input  wire logic        rel_dev_access,
	input  wire logic [1:0]  rel_companion,
	input  wire logic [15:0] rel_handle,
	output logic             mbx_valid,
	input  wire logic        mbx_ready,
	output logic [15:0]      mbx_word,
	output logic             mbx_last,
	output logic             irq
);
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic is_tbl(input logic [11:0] a);
		return a >= arind_pkg::OFS_TABLE && a < arind_pkg::OFS_TABLE + 12'h040;
	endfunction : is_tbl

	function automatic logic [15:0] type_code(input logic [2:0] k);
		case (k)
			arind_pkg::KIND_REDUN: type_code = arind_pkg::REL_TYPE_REDUN_CAP;
			arind_pkg::KIND_CTRL: type_code = arind_pkg::REL_TYPE_CTRL_RED;
			arind_pkg::KIND_DEV: type_code = arind_pkg::REL_TYPE_DEV_RED;
			arind_pkg::KIND_SUPER: type_code = arind_pkg::REL_TYPE_SUPERVISOR;
			default: type_code = arind_pkg::REL_TYPE_SINGLE;
		endcase
	endfunction : type_code

	logic                   rel_info_q;
	logic [2:0]             stat_q;
	logic [2:0]             mask_q;
	logic [2:0]             nmod_q;
	logic [31:0]            tbl_q [16];
	logic                   aw_hold_q;
	logic                   w_hold_q;
	logic [11:0]            waddr_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;
	logic                   do_wr;
	logic                   wr_ok;
	logic [31:0]            wmerged;
	logic [31:0]            rd_val;
	logic                   rd_ok;
	arind_pkg::arind_state_t state_q;
	logic                   kind_cfg_q;
	logic [3:0]             hidx_q;
	logic [5:0]             pos_q;
	logic [1:0]             mod_q;
	logic [3:0]             blk_q;
	logic [2:0]             fcnt_q;
	logic [15:0]            frag_q;
	logic [15:0]            msg_id_q;
	logic                   pend_q;
	logic [15:0]            type_q;
	logic [31:0]            props_q;
	logic [15:0]            handle_q;
	logic [5:0]             tot_w;
	logic [15:0]            tot_frag;
	logic [5:0]             remain;
	logic [15:0]            size_bytes;
	logic                   adv;
	logic                   free;
	logic                   capture;
	logic                   cur_last;
	logic                   rel_done;
	logic                   cfg_done;
	logic [15:0]            hdr_word;
	logic [15:0]            pay_word;

	assign awready = !aw_hold_q && !bvalid;
	assign wready = !w_hold_q && !bvalid;
	assign do_wr = aw_hold_q && w_hold_q && !bvalid;
	assign arready = !rvalid;
	assign irq = |(stat_q & mask_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid <= 1'b0;
			bresp <= arind_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_hold_q <= 1'b1;
				waddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? arind_pkg::RESP_OKAY : arind_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_ok = 1'b1;
		wmerged = 32'h0000_0000;
		if (waddr_q == arind_pkg::OFS_CTRL) begin
			wmerged = merge({31'h0000_0000, rel_info_q}, wdata_q, wstrb_q);
		end else if (waddr_q == arind_pkg::OFS_MASK) begin
			wmerged = merge({29'h0000_0000, mask_q}, wdata_q, wstrb_q);
		end else if (waddr_q == arind_pkg::OFS_NMOD) begin
			wmerged = merge({29'h0000_0000, nmod_q}, wdata_q, wstrb_q);
		end else if (is_tbl(waddr_q)) begin
			wmerged = merge(tbl_q[waddr_q[5:2]], wdata_q, wstrb_q);
		end else if (waddr_q != arind_pkg::OFS_STAT) begin
			wr_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rel_info_q <= 1'b0;
			mask_q <= '0;
			nmod_q <= '0;
		end else if (do_wr) begin
			if (waddr_q == arind_pkg::OFS_CTRL) begin
				rel_info_q <= wmerged[arind_pkg::CTRL_REL_INFO];
			end else if (waddr_q == arind_pkg::OFS_MASK) begin
				mask_q <= wmerged[arind_pkg::IRQ_W-1:0];
			end else if (waddr_q == arind_pkg::OFS_NMOD) begin
				nmod_q <= (wmerged > 32'(arind_pkg::MAX_MOD)) ? arind_pkg::MAX_MOD
					: wmerged[2:0];
			end
		end
	end

	generate
		for (genvar g = 0; g < 16; g++) begin : g_tbl
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					tbl_q[g] <= '0;
				end else if (do_wr && is_tbl(waddr_q) && waddr_q[5:2] == 4'(g)) begin
					tbl_q[g] <= wmerged;
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~((do_wr && waddr_q == arind_pkg::OFS_STAT)
				? (wdata_q[2:0] & {3{wstrb_q[0]}}) : 3'h0))
				| {(rel_est && rel_info_q && !free), cfg_done, rel_done};
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		rd_val = 32'h0000_0000;
		if (araddr == arind_pkg::OFS_CTRL) begin
			rd_val[arind_pkg::CTRL_REL_INFO] = rel_info_q;
		end else if (araddr == arind_pkg::OFS_STAT) begin
			rd_val[arind_pkg::IRQ_W-1:0] = stat_q;
		end else if (araddr == arind_pkg::OFS_MASK) begin
			rd_val[arind_pkg::IRQ_W-1:0] = mask_q;
		end else if (araddr == arind_pkg::OFS_NMOD) begin
			rd_val[2:0] = nmod_q;
		end else if (araddr == arind_pkg::OFS_STATE) begin
			rd_val = {frag_q, 12'h000, pend_q, state_q};
		end else if (is_tbl(araddr)) begin
			rd_val = tbl_q[araddr[5:2]];
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= arind_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_ok ? arind_pkg::RESP_OKAY : arind_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	assign tot_w = 6'(1 + arind_pkg::BLK_WORDS * int'(nmod_q));
	assign tot_frag = 16'((int'(tot_w) + arind_pkg::FRAG_WORDS - 1) >> arind_pkg::FRAG_SHIFT);
	assign remain = tot_w - pos_q;
	assign size_bytes = (remain > 6'(arind_pkg::FRAG_WORDS))
		? 16'(arind_pkg::FRAG_WORDS * 2) : {9'h000, remain, 1'b0};
	assign adv = !mbx_valid || mbx_ready;
	assign free = !pend_q && state_q == arind_pkg::ARIND_IDLE;
	assign capture = rel_est && rel_info_q && free;
	assign rel_done = adv && state_q == arind_pkg::ARIND_HDR && !kind_cfg_q
		&& hidx_q == arind_pkg::HW_LAST;
	assign cfg_done = adv && state_q == arind_pkg::ARIND_DATA && pos_q == tot_w - 6'h01;
	assign cur_last = rel_done || cfg_done || (state_q == arind_pkg::ARIND_DATA
		&& fcnt_q == 3'(arind_pkg::FRAG_WORDS - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= 1'b0;
			type_q <= '0;
			props_q <= '0;
			handle_q <= '0;
		end else if (capture) begin
			pend_q <= 1'b1;
			type_q <= type_code(rel_kind);
			props_q <= {{arind_pkg::PROP_PAD_W{1'b0}}, rel_companion, rel_dev_access, 1'b0,
				rel_rate, rel_param_cm, rel_takeover, rel_state};
			handle_q <= rel_handle;
		end else if (state_q == arind_pkg::ARIND_IDLE) begin
			pend_q <= 1'b0;
		end
	end

	always_comb begin
		case (hidx_q)
			arind_pkg::HW_ID: hdr_word = msg_id_q;
			arind_pkg::HW_INFO: hdr_word = arind_pkg::MSG_INFO;
			arind_pkg::HW_CMD: hdr_word = kind_cfg_q ? arind_pkg::CMD_CFG_REP
				: arind_pkg::CMD_NEW_REL;
			arind_pkg::HW_SIZE: hdr_word = kind_cfg_q ? size_bytes : arind_pkg::ZERO_WORD;
			arind_pkg::HW_FCNT: hdr_word = arind_pkg::FRAME_ONE;
			arind_pkg::HW_FNUM: hdr_word = arind_pkg::FRAME_ONE;
			arind_pkg::HW_EXT1: hdr_word = kind_cfg_q ? frag_q : type_q;
			arind_pkg::HW_EXT2: hdr_word = kind_cfg_q ? tot_frag : props_q[31:16];
			arind_pkg::HW_EXT3: hdr_word = kind_cfg_q ? handle_q : props_q[15:0];
			arind_pkg::HW_EXT4: hdr_word = kind_cfg_q ? arind_pkg::ZERO_WORD : handle_q;
			default: hdr_word = arind_pkg::ZERO_WORD;
		endcase
	end

	always_comb begin
		case (blk_q)
			arind_pkg::BK_SLOT: pay_word = tbl_q[{mod_q, arind_pkg::TW_SLOT}][15:0];
			arind_pkg::BK_NSUB: pay_word = arind_pkg::SUB_PER_SLOT;
			arind_pkg::BK_MIDH: pay_word = tbl_q[{mod_q, arind_pkg::TW_MODID}][31:16];
			arind_pkg::BK_MIDL: pay_word = tbl_q[{mod_q, arind_pkg::TW_MODID}][15:0];
			arind_pkg::BK_SSLOT: pay_word = tbl_q[{mod_q, arind_pkg::TW_SLOT}][31:16];
			arind_pkg::BK_SIDH: pay_word = tbl_q[{mod_q, arind_pkg::TW_SUBID}][31:16];
			arind_pkg::BK_SIDL: pay_word = tbl_q[{mod_q, arind_pkg::TW_SUBID}][15:0];
			arind_pkg::BK_INL: pay_word = tbl_q[{mod_q, arind_pkg::TW_LEN}][31:16];
			default: pay_word = tbl_q[{mod_q, arind_pkg::TW_LEN}][15:0];
		endcase
		if (pos_q == 6'h00) begin
			pay_word = {13'h0000, nmod_q};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mbx_valid <= 1'b0;
			mbx_word <= '0;
			mbx_last <= 1'b0;
		end else if (adv) begin
			mbx_valid <= state_q != arind_pkg::ARIND_IDLE;
			mbx_word <= (state_q == arind_pkg::ARIND_DATA) ? pay_word : hdr_word;
			mbx_last <= cur_last;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msg_id_q <= '0;
		end else if (adv && cur_last) begin
			msg_id_q <= msg_id_q + 16'h0001;
		end
	end

	// Messages go out back to back; only mbx_ready from the host paces their words.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= arind_pkg::ARIND_IDLE;
			kind_cfg_q <= 1'b0;
			hidx_q <= '0;
			pos_q <= '0;
			mod_q <= '0;
			blk_q <= '0;
			fcnt_q <= '0;
			frag_q <= '0;
		end else begin
			case (state_q)
				arind_pkg::ARIND_IDLE: begin
					if (pend_q) begin
						state_q <= arind_pkg::ARIND_HDR;
						kind_cfg_q <= 1'b0;
						hidx_q <= '0;
						pos_q <= '0;
						mod_q <= '0;
						blk_q <= '0;
						fcnt_q <= '0;
						frag_q <= 16'h0001;
					end
				end
				arind_pkg::ARIND_HDR: begin
					if (adv) begin
						hidx_q <= hidx_q + 4'h1;
						if (hidx_q == arind_pkg::HW_LAST && kind_cfg_q) begin
							state_q <= arind_pkg::ARIND_DATA;
							fcnt_q <= '0;
						end else if (hidx_q == arind_pkg::HW_LAST) begin
							kind_cfg_q <= 1'b1;
						end
					end
				end
				arind_pkg::ARIND_DATA: begin
					if (adv) begin
						pos_q <= pos_q + 6'h01;
						fcnt_q <= fcnt_q + 3'h1;
						if (pos_q != 6'h00 && blk_q == arind_pkg::BK_LAST) begin
							blk_q <= '0;
							mod_q <= mod_q + 2'h1;
						end else if (pos_q != 6'h00) begin
							blk_q <= blk_q + 4'h1;
						end
						if (cfg_done) begin
							state_q <= arind_pkg::ARIND_IDLE;
						end else if (fcnt_q == 3'(arind_pkg::FRAG_WORDS - 1)) begin
							state_q <= arind_pkg::ARIND_HDR;
							hidx_q <= '0;
							frag_q <= frag_q + 16'h0001;
						end
					end
				end
				default: state_q <= arind_pkg::ARIND_IDLE;
			endcase
		end
	end

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_rel_end;
		adv && state_q == arind_pkg::ARIND_HDR && !kind_cfg_q && hidx_q == arind_pkg::HW_LAST;
	endsequence
	sequence s_cfg_start;
		state_q == arind_pkg::ARIND_HDR && kind_cfg_q && hidx_q == arind_pkg::HW_ID;
	endsequence

	a_rel_cmd_word: assert property (adv && state_q == arind_pkg::ARIND_HDR && !kind_cfg_q
		&& hidx_q == arind_pkg::HW_CMD |=> mbx_word == arind_pkg::CMD_NEW_REL)
		else $error("new relationship command word wrong");
	a_disabled_quiet: assert property (rel_est && !rel_info_q && free |=> !pend_q)
		else $error("event accepted while disabled");
	a_no_wait_host: assert property (s_rel_end |=> s_cfg_start)
		else $error("report did not follow new relationship message");
	a_info_word: assert property (adv && state_q == arind_pkg::ARIND_HDR
		&& hidx_q == arind_pkg::HW_INFO |=> mbx_word == arind_pkg::MSG_INFO)
		else $error("message information word wrong");
	a_type_code: assert property (capture && rel_kind == arind_pkg::KIND_SUPER
		|=> type_q == arind_pkg::REL_TYPE_SUPERVISOR)
		else $error("relationship type code wrong");
	a_props_unused: assert property (capture |=> (props_q & arind_pkg::PROP_UNUSED_MASK) == 0
		&& props_q[2:0] == $past(rel_state))
		else $error("properties layout wrong");
	a_frag_ext: assert property (adv && state_q == arind_pkg::ARIND_HDR && kind_cfg_q
		&& hidx_q == arind_pkg::HW_EXT1 |=> mbx_word == $past(frag_q))
		else $error("fragment number word wrong");
	a_final_frag: assert property (cfg_done |-> frag_q == tot_frag)
		else $error("last fragment number differs from total");
	a_count_first: assert property (adv && state_q == arind_pkg::ARIND_DATA && pos_q == 6'h00
		|=> mbx_word == 16'($past(nmod_q)))
		else $error("payload does not open with module count");
	a_nsub_one: assert property (adv && state_q == arind_pkg::ARIND_DATA && pos_q != 6'h00
		&& blk_q == arind_pkg::BK_NSUB |=> mbx_word == arind_pkg::SUB_PER_SLOT)
		else $error("submodule count not one");
	a_unused_ext: assert property (adv && state_q == arind_pkg::ARIND_HDR
		&& hidx_q >= arind_pkg::HW_EXT5 |=> mbx_word == arind_pkg::ZERO_WORD)
		else $error("unused extended word not zero");
endmodule : arind_framer
`default_nettype wire

// >>> arind_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module arind_host_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        stall,
	input  wire logic        mbx_valid,
	input  wire logic [15:0] mbx_word,
	input  wire logic        mbx_last,
	output logic             mbx_ready
);
	logic [16:0] mem [0:511];
	int          cnt = 0;
	logic [1:0]  ph_q;
	// The host only takes words and never sends anything back.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_q      <= 2'h0;
			mbx_ready <= 1'b0;
		end else begin
			ph_q      <= ph_q + 2'h1;
			mbx_ready <= !stall || (ph_q == 2'h3);
		end
	end
	// Words are only stored, with their last flag; the testbench reads them from mem.
	always @(posedge aclk) begin
		if (aresetn && mbx_valid && mbx_ready) begin
			mem[cnt] <= {mbx_last, mbx_word};
			cnt      <= cnt + 1;
		end
	end
endmodule : arind_host_model
`default_nettype wire

// >>> tb_ar_indication_messages.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ar_indication_messages;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic        awready, wready, arready, rel_est, rel_takeover, rel_param_cm;
	logic        rel_dev_access, mbx_valid, mbx_ready, mbx_last, irq, stall;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rel_rate, rel_companion;
	logic [2:0]  rel_kind, rel_state;
	logic [15:0] rel_handle, mbx_word;
	logic [17:0] exq [$];
	logic [15:0] rtype [5] = '{16'h0001, 16'h0003, 16'h0004, 16'h0005, 16'h0006};
	int          error_cnt = 0;
	int          num_checks = 0;

	arind_framer arind_framer_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rel_est(rel_est), .rel_kind(rel_kind), .rel_state(rel_state),
		.rel_takeover(rel_takeover), .rel_param_cm(rel_param_cm), .rel_rate(rel_rate),
		.rel_dev_access(rel_dev_access), .rel_companion(rel_companion),
		.rel_handle(rel_handle), .mbx_valid(mbx_valid), .mbx_ready(mbx_ready),
		.mbx_word(mbx_word), .mbx_last(mbx_last), .irq(irq));
	arind_host_model arind_host_model_inst (.aclk(aclk), .aresetn(aresetn), .stall(stall),
		.mbx_valid(mbx_valid), .mbx_word(mbx_word), .mbx_last(mbx_last),
		.mbx_ready(mbx_ready));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic tmo(input string m);
		chk(1'b0, m);
		print_verdict();
	endtask : tmo

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		@(posedge aclk);
		if (n == 50) tmo("write hang");
		chk(r === er, "write response");
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		@(posedge aclk);
		if (n == 50) tmo("read hang");
	endtask : axi_rd

	task automatic irq_is(input logic v);
		@(negedge aclk);
		chk(irq === v, "interrupt level");
		@(posedge aclk);
	endtask : irq_is

	function automatic logic [15:0] props(input int k);
		return {5'h0, 2'(k % 3), k[1], 1'b0, 2'(k), !k[0], k[0], 3'(k)};
	endfunction : props

	task automatic push_hdr(input logic [15:0] cmd, sz, e1, e2, e3, e4);
		logic [15:0] w [16];
		w = '{16'h0, 16'h4002, cmd, sz, 16'h0001, 16'h0001, 16'h0, 16'h0, e1, e2, e3, e4,
			16'h0, 16'h0, 16'h0, 16'h0};
		for (int i = 0; i < 16; i++) exq.push_back({i == 0, i == 15 && sz == 16'h0, w[i]});
	endtask : push_hdr

	task automatic exp_event(input int k, input logic [15:0] h, input int n);
		logic [15:0] pl [$];
		int nf, sz;
		exq.delete();
		push_hdr(16'h0116, 16'h0, rtype[k], 16'h0, props(k), h);
		pl.push_back(16'(n));
		for (int m = 0; m < n; m++) begin
			pl = {pl, 16'h0010 + 16'(m), 16'h0001, 16'h4a6f, 16'h4862 + 16'(m)};
			pl = {pl, 16'h0001, 16'h656c, 16'h6965 + 16'(m), 16'h0004 + 16'(m)};
			pl.push_back(16'h0010 + 16'(m));
		end
		nf = (pl.size() + 7) / 8;
		for (int f = 1; f <= nf; f++) begin
			sz = (pl.size() < 8) ? pl.size() : 8;
			push_hdr(16'h0117, 16'(2 * sz), 16'(f), 16'(nf), h, 16'h0);
			for (int i = 0; i < sz; i++) exq.push_back({1'b0, i == sz - 1, pl.pop_front()});
		end
	endtask : exp_event

	task automatic fire(input int k, input logic [15:0] h);
		rel_kind <= 3'(k);
		rel_state <= 3'(k);
		rel_takeover <= k[0];
		rel_param_cm <= !k[0];
		rel_rate <= 2'(k);
		rel_dev_access <= k[1];
		rel_companion <= 2'(k % 3);
		rel_handle <= h;
		rel_est <= 1'b1;
		@(posedge aclk);
		rel_est <= 1'b0;
	endtask : fire

	task automatic check_msgs(input int base);
		int n;
		for (n = 0; n < 3000 && arind_host_model_inst.cnt < base + exq.size(); n++) @(posedge aclk);
		if (n == 3000) tmo("mailbox hang");
		repeat (40) @(posedge aclk);
		chk(arind_host_model_inst.cnt == base + exq.size(), "message count");
		foreach (exq[i]) chk(exq[i][17] || arind_host_model_inst.mem[base + i] === exq[i][16:0],
			$sformatf("word %0d", i));
	endtask : check_msgs

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		logic [11:0] offs [4] = '{arind_pkg::OFS_CTRL, arind_pkg::OFS_STAT,
			arind_pkg::OFS_MASK, arind_pkg::OFS_NMOD};
		foreach (offs[i]) begin
			axi_rd(offs[i], d, r);
			chk(d === 32'h0 && r === 2'h0, "reset value");
		end
		axi_rd(12'h020, d, r);
		chk(r === 2'h2, "unmapped read");
		axi_wr(12'h024, 32'h1, 2'h2);
		irq_is(1'b0);
	endtask : t_regs

	task automatic t_disabled();
		int base;
		base = arind_host_model_inst.cnt;
		fire(0, 16'h0bad);
		repeat (200) @(posedge aclk);
		chk(arind_host_model_inst.cnt == base, "message while disabled");
	endtask : t_disabled

	task automatic t_event(input int k, input logic [15:0] h, input int n);
		int base;
		base = arind_host_model_inst.cnt;
		exp_event(k, h, n);
		fire(k, h);
		check_msgs(base);
	endtask : t_event

	task automatic t_irq();
		logic [31:0] d;
		logic [1:0] r;
		int base;
		axi_rd(arind_pkg::OFS_STAT, d, r);
		chk(d[2:0] === 3'h3, "status after messages");
		irq_is(1'b0);
		axi_wr(arind_pkg::OFS_MASK, 32'h7, 2'h0);
		irq_is(1'b1);
		axi_wr(arind_pkg::OFS_STAT, 32'h3, 2'h0);
		irq_is(1'b0);
		base = arind_host_model_inst.cnt;
		exp_event(0, 16'h3000, 0);
		fire(0, 16'h3000);
		repeat (3) @(posedge aclk);
		fire(2, 16'h3001);
		check_msgs(base);
		axi_rd(arind_pkg::OFS_STAT, d, r);
		chk(d[2:0] === 3'h7, "lost event status");
		axi_wr(arind_pkg::OFS_STAT, 32'h7, 2'h0);
		irq_is(1'b0);
	endtask : t_irq

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, rel_est, stall} = '0;
		{rel_takeover, rel_param_cm, rel_dev_access, rel_rate, rel_companion} = '0;
		{awaddr, araddr, wdata, wstrb, rel_kind, rel_state, rel_handle} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_disabled();
		axi_wr(arind_pkg::OFS_CTRL, 32'h1, 2'h0);
		for (int k = 0; k < 5; k++) t_event(k, 16'h1000 + 16'(k), 0);
		for (int m = 0; m < 4; m++) begin
			axi_wr(arind_pkg::OFS_TABLE + 12'(16 * m), {16'h0001, 16'h0010 + 16'(m)}, 2'h0);
			axi_wr(arind_pkg::OFS_TABLE + 12'(16 * m + 4), 32'h4a6f_4862 + m, 2'h0);
			axi_wr(arind_pkg::OFS_TABLE + 12'(16 * m + 8), 32'h656c_6965 + m, 2'h0);
			axi_wr(arind_pkg::OFS_TABLE + 12'(16 * m + 12), {16'h0004 + 16'(m), 16'h0010 + 16'(m)}, 2'h0);
		end
		stall <= 1'b1;
		for (int n = 2; n <= 4; n += 2) begin
			axi_wr(arind_pkg::OFS_NMOD, 32'(n), 2'h0);
			t_event(1, 16'h2000 + 16'(n), n);
		end
		stall <= 1'b0;
		axi_wr(arind_pkg::OFS_NMOD, 32'h0, 2'h0);
		t_irq();
		print_verdict();
	end

	initial begin
		repeat (100000) @(posedge aclk);
		tmo("run timeout");
	end
endmodule : tb_ar_indication_messages
`default_nettype wire
